// File: hdl/mb_query_master.v
// Query command interpreter: reads a command block, sends a query, stores the answer
`include "mb_query_regs.vh"
module mb_query_master #(
  parameter TICKS_PER_SECOND = `CORE_CLK_HZ,
  parameter FIFO_DEPTH = 16
) (
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire i_CMD_START,
  input wire [15:0] i_CMD_BASE,
  output reg o_BUSY,
  output reg o_DONE,
  output reg o_MEM_RD,
  output reg o_MEM_WR,
  output reg [15:0] o_MEM_ADDR,
  output reg [15:0] o_MEM_WDATA,
  input wire [15:0] i_MEM_RDATA,
  output reg o_TX_ASCII,
  output wire o_TX_VALID,
  input wire i_TX_READY,
  output wire [7:0] o_TX_DATA,
  output wire o_TX_LAST,
  input wire i_RX_VALID,
  output wire o_RX_READY,
  input wire [7:0] i_RX_DATA,
  input wire i_RX_LAST
);

  ////////////////////////////////////////////////////////////////////////////////
  // States
  localparam ST_IDLE = 4'h0; // Waiting for a start
  localparam ST_FETCH = 4'h1; // Issue read of a block word
  localparam ST_FWAIT = 4'h2; // Capture the block word
  localparam ST_CHECK = 4'h3; // Validate fields
  localparam ST_HDR = 4'h4; // Push slave address and function code
  localparam ST_QREAD = 4'h5; // Issue read of a query data word
  localparam ST_QWAIT = 4'h6; // Capture the query data word
  localparam ST_QPUSH = 4'h7; // Push query data bytes
  localparam ST_RESP = 4'h8; // Take response bytes
  localparam ST_COUNT = 4'h9; // Store response byte count
  localparam ST_ERROR = 4'ha; // Write error word
  localparam ST_FINISH = 4'hb; // Release busy

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer registers and command block copies
  reg [3:0] state; // Current state
  reg [3:0] fetch_index; // Block word being read
  reg [15:0] base; // Command block location
  reg [15:0] command_code_word; // Query kind
  reg [15:0] slave_address_word; // Target slave
  reg [15:0] function_code_word; // Query function
  reg [15:0] query_data_pointer; // Query data location
  reg [15:0] query_data_length; // Query data bytes
  reg [15:0] response_pointer; // Response location
  reg [15:0] response_reserve_size; // Bytes host reserved
  reg [15:0] command_timeout_seconds; // Seconds allowed
  reg [15:0] byte_index; // Query byte or response data byte
  reg [15:0] data_word; // Query word being split
  reg [7:0] held_byte; // Even response byte awaiting its partner
  reg [15:0] error_code; // Code to write
  reg hdr_second; // Function code is next header byte
  reg rx_first; // Next response byte is the function code
  reg [31:0] tick_count; // Cycles within the current second
  reg [15:0] second_count; // Seconds elapsed

  wire fifo_ready; // Room in the transmit FIFO
  reg push_valid; // Byte offered to the FIFO
  reg [7:0] push_byte; // Byte offered
  reg push_last; // Final byte of the query

  wire broadcast = (slave_address_word == 16'h0000);
  wire special_fc = (function_code_word[7:0] == `FC_FORCE_COILS) ||
                    (function_code_word[7:0] == `FC_PRESET_REGS);
  wire [15:0] timeout_limit = (command_timeout_seconds == 16'h0000) ?
                              `DEFAULT_TIMEOUT_SECONDS : command_timeout_seconds;
  wire timeout_armed = !broadcast &&
                       (command_timeout_seconds <= `INFINITE_TIMEOUT_ABOVE);
  wire timed_out = timeout_armed && (second_count >= timeout_limit);
  wire sending = (state == ST_HDR) || (state == ST_QREAD) ||
                 (state == ST_QWAIT) || (state == ST_QPUSH);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a byte index is the last query byte
  function last_of;
    input [15:0] idx;
    input [15:0] len;
    begin
      last_of = (idx + 16'h0001 == len);
    end
  endfunction

  // True when the high byte of this query word is to be left out
  function skip_high;
    input [15:0] idx;
    input special;
    begin
      skip_high = special && (idx == `BYTE_COUNT_BYTE_INDEX);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Byte offered to the FIFO; the FIFO ready stalls the state machine
  always @* begin
    push_valid = 1'b0;
    push_byte = 8'h00;
    push_last = 1'b0;
    if (state == ST_HDR) begin
      // Slave address first, function code second
      push_valid = 1'b1;
      push_byte = hdr_second ? function_code_word[7:0] : slave_address_word[7:0];
      push_last = hdr_second && (query_data_length == 16'h0000);
    end else if (state == ST_QPUSH) begin
      // High byte at even index, low byte at odd index
      push_valid = 1'b1;
      push_byte = byte_index[0] ? data_word[7:0] : data_word[15:8];
      push_last = last_of(byte_index, query_data_length);
    end
  end

  assign o_RX_READY = (state == ST_RESP);

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit buffer toward the framing logic
  mb_byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_tx_fifo (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_ready),
    .i_in_data({push_last, push_byte}),
    .o_out_valid(o_TX_VALID),
    .i_out_ready(i_TX_READY),
    .o_out_data({o_TX_LAST, o_TX_DATA})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command timer: whole seconds since fetch ended, cleared when idle
  always @(posedge I_CORE_CLK) begin
    if (I_RST || state == ST_IDLE || state == ST_FETCH || state == ST_FWAIT) begin
      tick_count <= 32'h00000000;
      second_count <= 16'h0000;
    end else if (tick_count == TICKS_PER_SECOND - 1) begin
      tick_count <= 32'h00000000;
      // Saturate so an unlimited command never wraps into a false expiry
      if (second_count != 16'hffff) begin
        second_count <= second_count + 16'h0001;
      end
    end else begin
      tick_count <= tick_count + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state <= ST_IDLE;
      fetch_index <= 4'h0;
      base <= 16'h0000;
      command_code_word <= 16'h0000;
      slave_address_word <= 16'h0000;
      function_code_word <= 16'h0000;
      query_data_pointer <= 16'h0000;
      query_data_length <= 16'h0000;
      response_pointer <= 16'h0000;
      response_reserve_size <= 16'h0000;
      command_timeout_seconds <= 16'h0000;
      byte_index <= 16'h0000;
      data_word <= 16'h0000;
      held_byte <= 8'h00;
      error_code <= 16'h0000;
      hdr_second <= 1'b0;
      rx_first <= 1'b0;
      o_BUSY <= 1'b0;
      o_DONE <= 1'b0;
      o_MEM_RD <= 1'b0;
      o_MEM_WR <= 1'b0;
      o_MEM_ADDR <= 16'h0000;
      o_MEM_WDATA <= 16'h0000;
      o_TX_ASCII <= 1'b0;
    end else begin
      // Strobes default low
      o_MEM_RD <= 1'b0;
      o_MEM_WR <= 1'b0;
      o_DONE <= 1'b0;
      if (timed_out && (sending || state == ST_RESP)) begin
        // Time limit overrides any sending or response step in progress
        error_code <= `ERR_TIMEOUT;
        state <= ST_ERROR;
      end else begin
        case (state)
          ST_IDLE: begin
            // Starts while busy are ignored: only this state looks
            if (i_CMD_START) begin
              base <= i_CMD_BASE;
              o_BUSY <= 1'b1;
              fetch_index <= `OFF_COMMAND_CODE;
              state <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            // Flag and connection words are read but not acted on
            o_MEM_RD <= 1'b1;
            o_MEM_ADDR <= base + {12'h000, fetch_index};
            state <= ST_FWAIT;
          end
          ST_FWAIT: begin
            case (fetch_index)
              `OFF_COMMAND_CODE: command_code_word <= i_MEM_RDATA;
              `OFF_SLAVE_ADDRESS: slave_address_word <= i_MEM_RDATA;
              `OFF_FUNCTION_CODE: function_code_word <= i_MEM_RDATA;
              `OFF_QUERY_POINTER: query_data_pointer <= i_MEM_RDATA;
              `OFF_QUERY_LENGTH: query_data_length <= i_MEM_RDATA;
              `OFF_RESPONSE_POINTER: response_pointer <= i_MEM_RDATA;
              `OFF_RESPONSE_RESERVE: response_reserve_size <= i_MEM_RDATA;
              `OFF_TIMEOUT_SECONDS: command_timeout_seconds <= i_MEM_RDATA;
              default: data_word <= data_word;
            endcase
            if (fetch_index == `OFF_TIMEOUT_SECONDS) begin
              state <= ST_CHECK;
            end else begin
              fetch_index <= fetch_index + 4'h1;
              state <= ST_FETCH;
            end
          end
          ST_CHECK: begin
            // Field validation before anything goes on the line
            hdr_second <= 1'b0;
            byte_index <= 16'h0000;
            o_TX_ASCII <= (command_code_word == `CMD_ASCII_QUERY);
            if (command_code_word != `CMD_RTU_QUERY &&
                command_code_word != `CMD_ASCII_QUERY) begin
              error_code <= `ERR_BAD_COMMAND;
              state <= ST_ERROR;
            end else if (slave_address_word > `SLAVE_ADDRESS_MAX) begin
              error_code <= `ERR_BAD_SLAVE;
              state <= ST_ERROR;
            end else if (function_code_word == 16'h0000 ||
                         function_code_word > `FUNCTION_CODE_MAX) begin
              error_code <= `ERR_BAD_FUNCTION;
              state <= ST_ERROR;
            end else begin
              state <= ST_HDR;
            end
          end
          ST_HDR: begin
            // Address zero goes out unchanged as the broadcast address
            if (fifo_ready) begin
              hdr_second <= 1'b1;
              if (hdr_second) begin
                state <= (query_data_length == 16'h0000) ?
                         (broadcast ? ST_FINISH : ST_RESP) : ST_QREAD;
                rx_first <= 1'b1;
              end
            end
          end
          ST_QREAD: begin
            // One word read serves two bytes
            o_MEM_RD <= 1'b1;
            o_MEM_ADDR <= query_data_pointer + {1'b0, byte_index[15:1]};
            state <= ST_QWAIT;
          end
          ST_QWAIT: begin
            data_word <= i_MEM_RDATA;
            if (skip_high(byte_index, special_fc)) begin
              byte_index <= byte_index + 16'h0001;
            end
            state <= ST_QPUSH;
          end
          ST_QPUSH: begin
            if (fifo_ready) begin
              byte_index <= byte_index + 16'h0001;
              if (last_of(byte_index, query_data_length)) begin
                // Broadcasts expect no answer and end here
                state <= broadcast ? ST_FINISH : ST_RESP;
                rx_first <= 1'b1;
                byte_index <= 16'h0000;
              end else if (byte_index[0]) begin
                state <= ST_QREAD;
              end
            end
          end
          ST_RESP: begin
            if (i_RX_VALID) begin
              if (rx_first) begin
                rx_first <= 1'b0;
                if (i_RX_DATA != function_code_word[7:0] &&
                    i_RX_DATA != (function_code_word[7:0] | `EXCEPTION_BIT)) begin
                  error_code <= `ERR_FUNCTION_MISMATCH;
                  state <= ST_ERROR;
                end else if (response_reserve_size < `RESPONSE_OVERHEAD_BYTES) begin
                  error_code <= `ERR_RESPONSE_SIZE;
                  state <= ST_ERROR;
                end else begin
                  // Exception replies are stored like any other
                  o_MEM_WR <= 1'b1;
                  o_MEM_ADDR <= response_pointer;
                  o_MEM_WDATA <= {8'h00, i_RX_DATA};
                  if (i_RX_LAST) begin
                    state <= ST_COUNT;
                  end
                end
              end else if (byte_index + 16'h0001 + `RESPONSE_OVERHEAD_BYTES >
                           response_reserve_size) begin
                // Nothing past the reserve is touched
                error_code <= `ERR_RESPONSE_SIZE;
                state <= ST_ERROR;
              end else begin
                byte_index <= byte_index + 16'h0001;
                held_byte <= i_RX_DATA;
                if (byte_index[0] || i_RX_LAST) begin
                  // Pack data after the function code and count words
                  o_MEM_WR <= 1'b1;
                  o_MEM_ADDR <= response_pointer + 16'h0002 +
                                {1'b0, byte_index[15:1]};
                  o_MEM_WDATA <= byte_index[0] ? {held_byte, i_RX_DATA} :
                                 {i_RX_DATA, 8'h00};
                end
                if (i_RX_LAST) begin
                  state <= ST_COUNT;
                end
              end
            end
          end
          ST_COUNT: begin
            // Byte count word follows the function code word
            o_MEM_WR <= 1'b1;
            o_MEM_ADDR <= response_pointer + 16'h0001;
            o_MEM_WDATA <= byte_index;
            state <= ST_FINISH;
          end
          ST_ERROR: begin
            o_MEM_WR <= 1'b1;
            o_MEM_ADDR <= base + {12'h000, `OFF_ERROR_WORD};
            o_MEM_WDATA <= error_code;
            state <= ST_FINISH;
          end
          ST_FINISH: begin
            // Busy drops only after the last memory write is out
            o_BUSY <= 1'b0;
            o_DONE <= 1'b1;
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // mb_query_master

// File: hdl/mb_query_regs.vh
// Constants for the query command interpreter: block offsets, codes, limits, timing
`ifndef MB_QUERY_REGS_VH
`define MB_QUERY_REGS_VH
// Word offsets inside the command block
`define OFF_ERROR_WORD 4'h0
`define OFF_COMMAND_CODE 4'h1
`define OFF_CONNECTION 4'h2
`define OFF_COMMAND_FLAG 4'h3
`define OFF_SLAVE_ADDRESS 4'h4
`define OFF_FUNCTION_CODE 4'h5
`define OFF_QUERY_POINTER 4'h6
`define OFF_QUERY_LENGTH 4'h7
`define OFF_RESPONSE_POINTER 4'h8
`define OFF_RESPONSE_RESERVE 4'h9
`define OFF_TIMEOUT_SECONDS 4'ha
// Command codes
`define CMD_RTU_QUERY 16'h2801
`define CMD_ASCII_QUERY 16'h2901
// Field limits
`define SLAVE_ADDRESS_MAX 16'h00f7
`define FUNCTION_CODE_MAX 16'h007f
`define FC_FORCE_COILS 8'h0f
`define FC_PRESET_REGS 8'h10
`define EXCEPTION_BIT 8'h80
`define BYTE_COUNT_BYTE_INDEX 16'h0004
`define RESPONSE_OVERHEAD_BYTES 16'h0004
// Error codes written to the error word
`define ERR_TIMEOUT 16'h289d
`define ERR_BAD_COMMAND 16'h2890
`define ERR_BAD_SLAVE 16'h2891
`define ERR_BAD_FUNCTION 16'h2892
`define ERR_RESPONSE_SIZE 16'h2893
`define ERR_FUNCTION_MISMATCH 16'h2894
// Timing
`define CORE_CLK_HZ 250000000
`define DEFAULT_TIMEOUT_SECONDS 16'h0009
`define INFINITE_TIMEOUT_ABOVE 16'h03e7
`endif

// File: hdl/mb_byte_fifo.v
// Synchronous valid/ready FIFO held in flip-flops
module mb_byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_ptr; // Next slot to fill
  reg [AW-1:0] rd_ptr; // Oldest slot
  reg [AW:0] count; // Words held
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr];

  // Pointer and occupancy update; depth must be a power of two
  always @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // mb_byte_fifo

// File: test/vmem_model.sv
// Behavioural shared word memory standing in for the host controller
module vmem_model (
  input wire logic i_clk,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255]; // Word store; the bench fills command blocks here directly
  logic [15:0] idle_word; // Value shown while no read strobe stands
  initial idle_word = 16'h0000;
  // Read data stands while the strobe does: the design captures it at the edge that ends the strobe
  assign o_rdata = i_rd ? mem[i_addr[7:0]] : idle_word;
  // Idle value toggles each cycle so a capture outside the strobe shows up
  always @(posedge i_clk) begin
    idle_word <= ~idle_word;
    if (i_wr) begin
      mem[i_addr[7:0]] <= i_wdata;
    end
  end
endmodule // vmem_model

// File: test/mb_query_chk.sv
// Port-level assertions for the query command interpreter
module mb_query_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic i_CMD_START,
  input wire logic [15:0] i_CMD_BASE,
  input wire logic o_BUSY,
  input wire logic o_DONE,
  input wire logic o_MEM_RD,
  input wire logic o_MEM_WR,
  input wire logic [15:0] o_MEM_ADDR,
  input wire logic [15:0] o_MEM_WDATA,
  input wire logic o_TX_ASCII,
  input wire logic o_TX_VALID,
  input wire logic i_TX_READY,
  input wire logic [7:0] o_TX_DATA,
  input wire logic o_TX_LAST,
  input wire logic o_RX_READY,
  input wire logic i_RX_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] base_q; // Block address of the command in flight
  // Remember the block address so an error-word write can be recognised
  always @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      base_q <= 16'h0000;
    end else if (i_CMD_START && !o_BUSY) begin
      base_q <= i_CMD_BASE;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////
  start_busy_a: assert property (i_CMD_START && !o_BUSY |=> o_BUSY)
    else $error("busy did not follow an accepted start");
  done_pulse_a: assert property (o_DONE |=> !o_DONE)
    else $error("done lasted more than one cycle");
  done_idle_a: assert property (o_DONE |-> !o_BUSY)
    else $error("busy still high with done");
  err_then_done_a: assert property (o_MEM_WR && o_MEM_ADDR == base_q
    |-> o_MEM_WDATA != 16'h0000 ##1 o_DONE) else $error("error word write not ending command");
  idle_quiet_a: assert property (!o_BUSY |-> !o_MEM_RD && !o_MEM_WR)
    else $error("memory strobe while idle");
  rx_busy_a: assert property (o_RX_READY |-> o_BUSY)
    else $error("response accepted while idle");
  ascii_const_a: assert property (o_BUSY && ($past(o_TX_VALID) || $past(o_RX_READY))
    |-> $stable(o_TX_ASCII)) else $error("framing select changed mid transfer");
  tx_hold_a: assert property (o_TX_VALID && !i_TX_READY
    |=> o_TX_VALID && $stable(o_TX_DATA) && $stable(o_TX_LAST)) else $error("tx byte not held");
  // Main scenarios reached
  done_c: cover property (o_DONE);
  err_c: cover property (o_MEM_WR && o_MEM_ADDR == base_q);
  rx_c: cover property (i_RX_VALID && o_RX_READY);
  stall_c: cover property (o_TX_VALID && !i_TX_READY);
endmodule // mb_query_chk
bind mb_query_master mb_query_chk chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
  .i_CMD_START(i_CMD_START), .i_CMD_BASE(i_CMD_BASE), .o_BUSY(o_BUSY), .o_DONE(o_DONE),
  .o_MEM_RD(o_MEM_RD), .o_MEM_WR(o_MEM_WR), .o_MEM_ADDR(o_MEM_ADDR),
  .o_MEM_WDATA(o_MEM_WDATA), .o_TX_ASCII(o_TX_ASCII), .o_TX_VALID(o_TX_VALID),
  .i_TX_READY(i_TX_READY), .o_TX_DATA(o_TX_DATA), .o_TX_LAST(o_TX_LAST),
  .o_RX_READY(o_RX_READY), .i_RX_VALID(i_RX_VALID));

// File: test/tb.sv
// Self-checking bench for the query command interpreter
`include "mb_query_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TPS = 20; // Short second keeps timeouts to a few hundred cycles
  logic clk = 0;
  logic rst = 1;
  logic start = 0;
  logic tx_ready = 0;
  logic rx_valid = 0;
  logic rx_last = 0;
  logic [7:0] rx_data = 8'h00;
  logic busy, done, rd, wr, ascii, tx_valid, tx_last, rx_ready, ascii_seen;
  logic [15:0] addr, wdata, rdata;
  logic [7:0] tx_data;
  logic [7:0] rx_q[$], tx_q[$], exp_q[$]; // Response bytes, sent bytes, expected bytes
  int bad_count = 0;
  int samples_checked = 0;
  int took, last_at;
  mb_query_master #(.TICKS_PER_SECOND(TPS)) dut_u (.I_CORE_CLK(clk), .I_RST(rst),
    .i_CMD_START(start), .i_CMD_BASE(16'h0010), .o_BUSY(busy), .o_DONE(done), .o_MEM_RD(rd),
    .o_MEM_WR(wr), .o_MEM_ADDR(addr), .o_MEM_WDATA(wdata), .i_MEM_RDATA(rdata),
    .o_TX_ASCII(ascii), .o_TX_VALID(tx_valid), .i_TX_READY(tx_ready), .o_TX_DATA(tx_data),
    .o_TX_LAST(tx_last), .i_RX_VALID(rx_valid), .o_RX_READY(rx_ready), .i_RX_DATA(rx_data),
    .i_RX_LAST(rx_last));
  vmem_model mem_u (.i_clk(clk), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata));
  initial begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check16(input string name, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  // One command: fill the block, start, stall tx until hold, answer with rx_q once sent
  task automatic run_query(input logic [15:0] cmd, slave, fc, len, rsv, tmo, input int hold);
    int k, fin;
    k = 0;
    fin = 4000;
    last_at = -1;
    tx_q.delete();
    for (int i = 0; i < 16; i++) begin
      mem_u.mem[16 + i] = 16'h0000;
      mem_u.mem[128 + i] = 16'hbeef;
    end
    mem_u.mem[17] = cmd;
    mem_u.mem[18] = 16'd19221;
    mem_u.mem[20] = slave;
    mem_u.mem[21] = fc;
    mem_u.mem[22] = (len == 0) ? 16'h0000 : 16'h0040;
    mem_u.mem[23] = len;
    mem_u.mem[24] = 16'h0080;
    mem_u.mem[25] = rsv;
    mem_u.mem[26] = tmo;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // Keep draining the byte stream for a while after done; broadcasts end before it empties
    for (took = 0; took < fin + 24 && took < 4000; took++) begin
      @(posedge clk);
      if (tx_valid && tx_ready) begin
        tx_q.push_back(tx_data);
        if (tx_last) last_at = tx_q.size();
      end
      if (rx_valid && rx_ready) k++;
      if (busy) ascii_seen = ascii;
      if (done) fin = took;
      tx_ready <= ((took > hold) && took[0]) || fin < 4000;
      rx_valid <= last_at > 0 && took > hold && k < rx_q.size() && fin == 4000;
      rx_data <= (k < rx_q.size()) ? rx_q[k] : ~rx_data;
      rx_last <= (k == rx_q.size() - 1);
    end
    tx_ready <= 1'b0;
    took = fin;
    if (fin == 4000) begin
      $display("BAD done expected 1 seen 0");
      bad_count++;
      complete_run();
    end
  endtask
  task automatic check_tx;
    check16("tx count", 16'(exp_q.size()), 16'(tx_q.size()));
    check16("tx last", 16'(exp_q.size()), 16'(last_at));
    for (int i = 0; i < exp_q.size() && i < tx_q.size(); i++) begin
      check16("tx byte", {8'h00, exp_q[i]}, {8'h00, tx_q[i]});
    end
  endtask
  // Stored response: code word, count word, data packed high byte first, nothing beyond
  task automatic check_resp;
    logic [15:0] w;
    check16("resp code", {8'h00, rx_q[0]}, mem_u.mem[128]);
    check16("resp count", 16'(rx_q.size() - 1), mem_u.mem[129]);
    for (int i = 1; i < rx_q.size(); i += 2) begin
      w = {rx_q[i], (i + 1 < rx_q.size()) ? rx_q[i + 1] : 8'h00};
      check16("resp data", w, mem_u.mem[130 + i / 2]);
    end
    check16("resp end", 16'hbeef, mem_u.mem[130 + rx_q.size() / 2]);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_rtu_read;
    mem_u.mem[64] = 16'h006b;
    mem_u.mem[65] = 16'h0002;
    rx_q = '{8'h03, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
    exp_q = '{8'h11, 8'h03, 8'h00, 8'h6b, 8'h00, 8'h02};
    run_query(`CMD_RTU_QUERY, 16'h0011, 16'h0003, 16'h0004, 16'h0009, 16'h0000, 0);
    check_tx();
    check16("ascii", 16'h0000, {15'h0000, ascii_seen});
    check_resp();
    check16("error word", 16'h0000, mem_u.mem[16]);
  endtask
  // Long register preset: fills the byte buffer while the line stalls
  task automatic s_ascii_preset;
    exp_q = '{8'h05, 8'h10, 8'h00, 8'h01, 8'h00, 8'h0a, 8'h14};
    mem_u.mem[64] = 16'h0001;
    mem_u.mem[65] = 16'h000a;
    mem_u.mem[66] = 16'h0014;
    for (int i = 0; i < 10; i++) begin
      mem_u.mem[67 + i] = {8'(i), 8'(8'ha0 + i)};
      exp_q.push_back(8'(i));
      exp_q.push_back(8'(8'ha0 + i));
    end
    rx_q = '{8'h90, 8'h02};
    run_query(`CMD_ASCII_QUERY, 16'h0005, 16'h0010, 16'h001a, 16'h0005, 16'h03e8, 120);
    check_tx();
    check16("ascii", 16'h0001, {15'h0000, ascii_seen});
    check_resp();
    check16("error word", 16'h0000, mem_u.mem[16]);
  endtask
  task automatic s_bad_answers;
    rx_q = '{8'h05, 8'h00, 8'h01};
    run_query(`CMD_RTU_QUERY, 16'h00f7, 16'h0004, 16'h0004, 16'h0020, 16'h0000, 0);
    check16("error word", `ERR_FUNCTION_MISMATCH, mem_u.mem[16]);
    check16("resp untouched", 16'hbeef, mem_u.mem[128]);
    rx_q = '{8'h03, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
    run_query(`CMD_RTU_QUERY, 16'h0001, 16'h0003, 16'h0004, 16'h0008, 16'h0000, 0);
    check16("error word", `ERR_RESPONSE_SIZE, mem_u.mem[16]);
    check16("past reserve", 16'hbeef, mem_u.mem[132]);
  endtask
  task automatic s_timeouts;
    rx_q.delete();
    run_query(`CMD_RTU_QUERY, 16'h0001, 16'h0003, 16'h0004, 16'h0020, 16'h0002, 0);
    check16("error word", `ERR_TIMEOUT, mem_u.mem[16]);
    check16("short wait", 16'h0001, {15'h0000, took >= 2 * TPS && took < 9 * TPS});
    run_query(`CMD_RTU_QUERY, 16'h0001, 16'h0003, 16'h0004, 16'h0020, 16'h0000, 0);
    check16("error word", `ERR_TIMEOUT, mem_u.mem[16]);
    check16("default wait", 16'h0001, {15'h0000, took >= 9 * TPS && took < 9 * TPS + 80});
    rx_q = '{8'h03, 8'h02, 8'h12, 8'h34};
    run_query(`CMD_RTU_QUERY, 16'h0001, 16'h0003, 16'h0004, 16'h0020, 16'h03e8, 9 * TPS + 100);
    check16("error word", 16'h0000, mem_u.mem[16]);
    check_resp();
  endtask
  // Broadcast long enough to stall on the full byte buffer past its one-second limit
  task automatic s_broadcast;
    rx_q.delete();
    mem_u.mem[64] = 16'h006b;
    mem_u.mem[65] = 16'h0002;
    exp_q = '{8'h00, 8'h7f, 8'h00, 8'h6b, 8'h00, 8'h02};
    for (int i = 0; i < 11; i++) begin
      mem_u.mem[66 + i] = {8'(i), 8'h5a};
      exp_q.push_back(8'(i));
      exp_q.push_back(8'h5a);
    end
    run_query(`CMD_RTU_QUERY, 16'h0000, 16'h007f, 16'h001a, 16'h0020, 16'h0001, 60);
    check_tx();
    check16("error word", 16'h0000, mem_u.mem[16]);
    check16("resp untouched", 16'hbeef, mem_u.mem[128]);
  endtask
  task automatic s_refused;
    logic [15:0] tbl [4][4] = '{'{16'h2802, 16'h0001, 16'h0003, `ERR_BAD_COMMAND},
      '{`CMD_RTU_QUERY, 16'h00f8, 16'h0003, `ERR_BAD_SLAVE},
      '{`CMD_RTU_QUERY, 16'h0001, 16'h0000, `ERR_BAD_FUNCTION},
      '{`CMD_RTU_QUERY, 16'h0001, 16'h0080, `ERR_BAD_FUNCTION}};
    for (int i = 0; i < 4; i++) begin
      run_query(tbl[i][0], tbl[i][1], tbl[i][2], 16'h0004, 16'h0020, 16'h0000, 0);
      check16("refused code", tbl[i][3], mem_u.mem[16]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_rtu_read();
    s_ascii_preset();
    s_bad_answers();
    s_timeouts();
    s_broadcast();
    s_refused();
    complete_run();
  end
endmodule // tb
